// *** fpm_defines.svh ***
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

// ==========================================
// Geometry
`define FPM_NCHAN          8
`define FPM_NPIN           4
`define FPM_ZONE_SIZE      4
`define FPM_ODD_CHANS      8'hAA

// ==========================================
// Command codes on the paged register port
`define FPM_CMD_PROP_A     2'h0
`define FPM_CMD_PROP_B     2'h1
`define FPM_CMD_PGOOD_MASK 2'h2

// ==========================================
// Field positions and widths
`define FPM_PROP_BIT       0
`define FPM_MASK_W         9
`define FPM_MASK_WDOG_BIT  8
`define FPM_MASK_CHAN_MSB  7

// ==========================================
// Reset values
`define FPM_PROP_RST       8'h00
`define FPM_MASK_RST       9'h000
`define FPM_WORD_ZERO      16'h0000

// ==========================================
// Fault pin qualification time
`define FPM_CLK_NS         25
`define FPM_FILTER_NS      10000
`define FPM_FILTER_CYC     ((`FPM_FILTER_NS + `FPM_CLK_NS - 1) / `FPM_CLK_NS)
`define FPM_CNT_W          9

`endif

// *** fpm_pkg.sv ***
`default_nettype none

package fpm_pkg;

  // ==========================================
  // Register port carriers
  typedef logic [1:0] cmd_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    cmd_t        cmd;
    logic [2:0]  page;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } reg_rsp_s;

  // ==========================================
  // Fault pin qualifier states, Gray along the path
  typedef enum logic [1:0] {
    FLT_IDLE = 2'b00,
    FLT_QUAL = 2'b01,
    FLT_HELD = 2'b11
  } flt_state_e;

endpackage

`default_nettype wire

// *** fault_propagation_pgood_map.sv ***
`timescale 1ns/1ps
`include "fpm_defines.svh"
`default_nettype none

module fault_propagation_pgood_map (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire fpm_pkg::reg_req_s reg_req_i,
  output var  fpm_pkg::reg_rsp_s reg_rsp_o,
  input  wire logic [7:0]       faulted_off_i,
  input  wire logic [7:0]       fault_response_a_i,
  input  wire logic [7:0]       fault_response_b_i,
  input  wire logic [7:0]       hires_mode_i,
  input  wire logic [7:0]       chan_pgood_i,
  input  wire logic             wdog_not_expired_i,
  input  wire logic [7:0]       status_clear_i,
  input  wire logic             zone0_fault_pin_a_i,
  output logic                  zone0_fault_pin_a_o,
  output logic                  zone0_fault_pin_a_oe_o,
  input  wire logic             zone0_fault_pin_b_i,
  output logic                  zone0_fault_pin_b_o,
  output logic                  zone0_fault_pin_b_oe_o,
  input  wire logic             zone1_fault_pin_a_i,
  output logic                  zone1_fault_pin_a_o,
  output logic                  zone1_fault_pin_a_oe_o,
  input  wire logic             zone1_fault_pin_b_i,
  output logic                  zone1_fault_pin_b_o,
  output logic                  zone1_fault_pin_b_oe_o,
  output logic                  alert_out_n_o,
  output logic                  alert_out_n_oe_o,
  output logic                  power_good_o,
  output logic [7:0]            chan_pin_shutdown_o,
  output logic [7:0]            pin_shutdown_status_o
);
  import fpm_pkg::*;

  // ==========================================
  // Helpers

  // Pin index for a channel: zone in bit 1, pin B in bit 0
  function automatic logic [1:0] pin_for(input int unsigned chan, input logic pin_b);
    logic zone;
    zone = (chan >= `FPM_ZONE_SIZE);
    return {zone, pin_b};
  endfunction

  // ==========================================
  // Declarations
  logic [7:0]              prop_a;
  logic [7:0]              prop_b;
  logic [`FPM_MASK_W-1:0]  pgood_mask;
  logic [3:0]              pin_sync1;
  logic [3:0]              pin_sync2;
  flt_state_e              flt_state [`FPM_NPIN];
  flt_state_e              next_flt_state [`FPM_NPIN];
  logic [`FPM_CNT_W-1:0]   flt_cnt [`FPM_NPIN];
  logic [`FPM_CNT_W-1:0]   next_flt_cnt [`FPM_NPIN];
  logic [3:0]              pin_raw;
  logic [3:0]              pin_low;
  logic [3:0]              pin_held;
  logic [3:0]              pin_drive;
  logic [3:0]              next_pin_drive;
  logic [7:0]              next_shutdown;
  logic [7:0]              pgood_excl;
  logic [7:0]              pgood_use;
  logic                    next_pgood;
  logic                    wr_prop_a;
  logic                    wr_prop_b;
  logic                    wr_mask;
  logic [15:0]             rd_word;

  // ==========================================
  // Register port decode
  assign wr_prop_a = reg_req_i.wr && (reg_req_i.cmd == `FPM_CMD_PROP_A);
  assign wr_prop_b = reg_req_i.wr && (reg_req_i.cmd == `FPM_CMD_PROP_B);
  assign wr_mask   = reg_req_i.wr && (reg_req_i.cmd == `FPM_CMD_PGOOD_MASK);

  // Read mux; reserved bits are constant zero
  assign rd_word =
    (reg_req_i.cmd == `FPM_CMD_PROP_A)     ? {15'h0000, prop_a[reg_req_i.page]} :
    (reg_req_i.cmd == `FPM_CMD_PROP_B)     ? {15'h0000, prop_b[reg_req_i.page]} :
    (reg_req_i.cmd == `FPM_CMD_PGOOD_MASK) ? {7'h00, pgood_mask} :
                                             `FPM_WORD_ZERO;

  // Paged settings store only bit 0; mask stores nine bits
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prop_a     <= `FPM_PROP_RST;
      prop_b     <= `FPM_PROP_RST;
      pgood_mask <= `FPM_MASK_RST;
    end else begin
      if (wr_prop_a) prop_a[reg_req_i.page] <= reg_req_i.wdata[`FPM_PROP_BIT];
      if (wr_prop_b) prop_b[reg_req_i.page] <= reg_req_i.wdata[`FPM_PROP_BIT];
      if (wr_mask) pgood_mask <= reg_req_i.wdata[`FPM_MASK_W-1:0];
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rsp_o <= '0;
    end else begin
      reg_rsp_o.valid <= reg_req_i.rd;
      reg_rsp_o.rdata <= reg_req_i.rd ? rd_word : `FPM_WORD_ZERO;
    end
  end

  // ==========================================
  // Fault pin drive

  // Each faulted channel reaches only its own zone's pair
  always_comb begin
    next_pin_drive = '0;
    for (int c = 0; c < `FPM_NCHAN; c++) begin
      next_pin_drive[pin_for(c, 1'b0)] |= faulted_off_i[c] & prop_a[c];
      next_pin_drive[pin_for(c, 1'b1)] |= faulted_off_i[c] & prop_b[c];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) pin_drive <= '0;
    else         pin_drive <= next_pin_drive;
  end

  // Open drain: output level always low, enable pulls
  assign zone0_fault_pin_a_o    = 1'b0;
  assign zone0_fault_pin_b_o    = 1'b0;
  assign zone1_fault_pin_a_o    = 1'b0;
  assign zone1_fault_pin_b_o    = 1'b0;
  assign zone0_fault_pin_a_oe_o = pin_drive[0];
  assign zone0_fault_pin_b_oe_o = pin_drive[1];
  assign zone1_fault_pin_a_oe_o = pin_drive[2];
  assign zone1_fault_pin_b_oe_o = pin_drive[3];

  // ==========================================
  // Fault pin qualification

  assign pin_raw = {zone1_fault_pin_b_i, zone1_fault_pin_a_i,
                    zone0_fault_pin_b_i, zone0_fault_pin_a_i};

  // Two-stage synchroniser for the wired pins
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_sync1 <= 4'hF;
      pin_sync2 <= 4'hF;
    end else begin
      pin_sync1 <= pin_raw;
      pin_sync2 <= pin_sync1;
    end
  end

  assign pin_low = ~pin_sync2;

  // Pin must stay low the full qualification time before it counts
  always_comb begin
    for (int p = 0; p < `FPM_NPIN; p++) begin
      next_flt_state[p] = flt_state[p];
      next_flt_cnt[p]   = flt_cnt[p];
      case (flt_state[p])
        FLT_IDLE: begin
          next_flt_cnt[p] = '0;
          if (pin_low[p]) next_flt_state[p] = FLT_QUAL;
        end
        FLT_QUAL: begin
          if (!pin_low[p]) begin
            next_flt_state[p] = FLT_IDLE;
          end else if (flt_cnt[p] == `FPM_CNT_W'(`FPM_FILTER_CYC - 1)) begin
            next_flt_state[p] = FLT_HELD;
          end else begin
            next_flt_cnt[p] = flt_cnt[p] + 1'b1;
          end
        end
        FLT_HELD: begin
          if (!pin_low[p]) next_flt_state[p] = FLT_IDLE;
        end
        default: begin
          next_flt_state[p] = FLT_IDLE;
          next_flt_cnt[p]   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < `FPM_NPIN; p++) begin
        flt_state[p] <= FLT_IDLE;
        flt_cnt[p]   <= '0;
      end
    end else begin
      flt_state <= next_flt_state;
      flt_cnt   <= next_flt_cnt;
    end
  end

  always_comb begin
    for (int p = 0; p < `FPM_NPIN; p++) pin_held[p] = (flt_state[p] == FLT_HELD);
  end

  // ==========================================
  // Channel response to a held zone pin

  // Response zero leaves the channel running
  always_comb begin
    for (int c = 0; c < `FPM_NCHAN; c++) begin
      next_shutdown[c] = (fault_response_a_i[c] & pin_held[pin_for(c, 1'b0)]) |
                         (fault_response_b_i[c] & pin_held[pin_for(c, 1'b1)]);
    end
  end

  // Shutdown level, and sticky status where a new shutdown beats a clear
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_pin_shutdown_o   <= '0;
      pin_shutdown_status_o <= '0;
    end else begin
      chan_pin_shutdown_o   <= next_shutdown;
      pin_shutdown_status_o <= (pin_shutdown_status_o & ~status_clear_i)
                             | (next_shutdown & ~chan_pin_shutdown_o);
    end
  end

  // Alert pulls low while any status bit stands
  assign alert_out_n_o    = 1'b0;
  assign alert_out_n_oe_o = |pin_shutdown_status_o;

  // ==========================================
  // Power-good map

  assign pgood_excl = hires_mode_i & `FPM_ODD_CHANS;
  assign pgood_use  = pgood_mask[`FPM_MASK_CHAN_MSB:0] & ~pgood_excl;
  assign next_pgood = (&(chan_pgood_i | ~pgood_use))
                    & (wdog_not_expired_i | ~pgood_mask[`FPM_MASK_WDOG_BIT]);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) power_good_o <= 1'b0;
    else         power_good_o <= next_pgood;
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  chk_zone0_isolation: assert property (
    (faulted_off_i[3:0] == 4'h0) && (faulted_off_i[7:4] == 4'hF) && (prop_a[7:4] == 4'hF)
    |=> !zone0_fault_pin_a_oe_o && zone1_fault_pin_a_oe_o)
    else $error("zone 1 fault reached zone 0 pin");

  chk_zone1_isolation: assert property (
    (faulted_off_i[7:4] == 4'h0) && (faulted_off_i[3:0] == 4'hF) && (prop_b[3:0] == 4'hF)
    |=> !zone1_fault_pin_b_oe_o && zone0_fault_pin_b_oe_o)
    else $error("zone 0 fault reached zone 1 pin");

  chk_paged_write: assert property (
    wr_prop_b |=> prop_b[$past(reg_req_i.page)] == $past(reg_req_i.wdata[0]))
    else $error("paged propagate write lost");

  chk_pin_a_drive: assert property (
    faulted_off_i[5] && prop_a[5] |=> zone1_fault_pin_a_oe_o)
    else $error("faulted channel did not pull pin A");

  chk_pin_b_idle: assert property (
    (prop_b[3:0] == 4'h0) && $stable(prop_b) |=> !zone0_fault_pin_b_oe_o)
    else $error("pin B driven without propagate bit");

  chk_prop_reserved: assert property (
    reg_req_i.rd && (reg_req_i.cmd != `FPM_CMD_PGOOD_MASK)
    |=> reg_rsp_o.valid && (reg_rsp_o.rdata[15:1] == 15'h0000))
    else $error("propagate reserved bits not zero");

  chk_resp_ignore: assert property (
    (fault_response_a_i == 8'h00) && (fault_response_b_i == 8'h00)
    |=> chan_pin_shutdown_o == 8'h00)
    else $error("channel shut down with response zero");

  chk_pgood_chan: assert property (
    pgood_mask[2] && !chan_pgood_i[2] |=> !power_good_o)
    else $error("enabled channel failed to drop power good");

  chk_pgood_wdog: assert property (
    pgood_mask[8] && !wdog_not_expired_i |=> !power_good_o)
    else $error("watchdog expiry did not drop power good");

  chk_pgood_hires: assert property (
    (pgood_mask == 9'h002) && hires_mode_i[1] |=> power_good_o)
    else $error("odd high-res channel affected power good");

  chk_mask_reserved: assert property (
    reg_req_i.rd && (reg_req_i.cmd == `FPM_CMD_PGOOD_MASK)
    |=> reg_rsp_o.rdata[15:9] == 7'h00)
    else $error("mask reserved bits not zero");

  chk_filter_delay: assert property (
    $rose(pin_held[0]) |-> $past(pin_low[0], 400) && $past(pin_low[0], 1))
    else $error("zone pin qualified too early");

  chk_release_on: assert property (
    pin_held[0] && !pin_low[0] |=> !pin_held[0] ##1 !chan_pin_shutdown_o[0])
    else $error("channel not released after pin release");

  chk_alert_status: assert property (
    $rose(chan_pin_shutdown_o[6]) |-> pin_shutdown_status_o[6] && alert_out_n_oe_o)
    else $error("shutdown without status and alert");

  chk_open_drain: assert property (
    !zone0_fault_pin_a_o && !zone1_fault_pin_b_o && !alert_out_n_o)
    else $error("open-drain pin driven high");

  chk_empty_mask: assert property (
    pgood_mask == 9'h000 |=> power_good_o)
    else $error("empty mask did not assert power good");

  cov_pgood_rise: cover property ($rose(power_good_o));
  cov_shutdown: cover property ($rose(chan_pin_shutdown_o[0]));
  cov_pin_drive: cover property ($rose(zone1_fault_pin_b_oe_o));
  cov_status_clear: cover property ($fell(pin_shutdown_status_o[4]));

endmodule

`default_nettype wire

// *** fpm_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Peer supply managers on the shared fault pins
module fpm_peer_model (
  input  wire logic [3:0] peer_pull_i,
  input  wire logic [3:0] dev_oe_i,
  input  wire logic [3:0] dev_drv_i,
  output logic      [3:0] wire_level_o
);
  // Wired-AND with pull-up: any party pulling low wins
  assign wire_level_o = ~(peer_pull_i | (dev_oe_i & ~dev_drv_i));
endmodule

`default_nettype wire

// *** fault_propagation_pgood_map_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module fault_propagation_pgood_map_tb_top;
  import fpm_pkg::*;

  // ==========================================
  // Stimulus and observation signals
  logic       clk_sys = 1'b0;
  logic       rstn    = 1'b0;
  reg_req_s   req     = '0;
  reg_rsp_s   rsp;
  logic [7:0] faulted_off = '0, resp_a = '0, resp_b = '0, hires = '0;
  logic [7:0] pgood = '0, clr = '0, shut, status;
  logic       wdog = 1'b0, alert_n, alert_oe, pgood_pin;
  logic [3:0] peer_pull = '0, pin_lvl, dev_oe, dev_drv;
  logic [15:0] rd_val;
  int         miscompares = 0;
  int         samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  fault_propagation_pgood_map dut (
    .clk_sys_i(clk_sys), .rstn_i(rstn), .reg_req_i(req), .reg_rsp_o(rsp),
    .faulted_off_i(faulted_off), .fault_response_a_i(resp_a),
    .fault_response_b_i(resp_b), .hires_mode_i(hires), .chan_pgood_i(pgood),
    .wdog_not_expired_i(wdog), .status_clear_i(clr),
    .zone0_fault_pin_a_i(pin_lvl[0]), .zone0_fault_pin_a_o(dev_drv[0]),
    .zone0_fault_pin_a_oe_o(dev_oe[0]),
    .zone0_fault_pin_b_i(pin_lvl[1]), .zone0_fault_pin_b_o(dev_drv[1]),
    .zone0_fault_pin_b_oe_o(dev_oe[1]),
    .zone1_fault_pin_a_i(pin_lvl[2]), .zone1_fault_pin_a_o(dev_drv[2]),
    .zone1_fault_pin_a_oe_o(dev_oe[2]),
    .zone1_fault_pin_b_i(pin_lvl[3]), .zone1_fault_pin_b_o(dev_drv[3]),
    .zone1_fault_pin_b_oe_o(dev_oe[3]),
    .alert_out_n_o(alert_n), .alert_out_n_oe_o(alert_oe), .power_good_o(pgood_pin),
    .chan_pin_shutdown_o(shut), .pin_shutdown_status_o(status));

  fpm_peer_model peer (
    .peer_pull_i(peer_pull), .dev_oe_i(dev_oe), .dev_drv_i(dev_drv),
    .wire_level_o(pin_lvl));

  // ==========================================
  // Shared tasks
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr_reg(input cmd_t cmd, input logic [2:0] page, input logic [15:0] data);
    @(negedge clk_sys);
    req = '{wr: 1'b1, rd: 1'b0, cmd: cmd, page: page, wdata: data};
    @(negedge clk_sys);
    req = '0;
  endtask

  task automatic rd_reg(input cmd_t cmd, input logic [2:0] page, output logic [15:0] data);
    int i;
    @(negedge clk_sys);
    req = '{wr: 1'b0, rd: 1'b1, cmd: cmd, page: page, wdata: 16'h0000};
    @(negedge clk_sys);
    req = '0;
    for (i = 0; i < 4 && rsp.valid !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    if (rsp.valid !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    data = rsp.rdata;
  endtask

  // Reference power-good AND built from the mask semantics
  function automatic logic pg_ref(input logic [8:0] m, input logic [7:0] pg,
                                  input logic [7:0] hi, input logic wd);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && !(i % 2 == 1 && hi[i])) r &= pg[i];
    end
    if (m[8]) r &= wd;
    return r;
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    int n;
    int h;
    logic [8:0] m;
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    idle(2);
    check(16'(pgood_pin), 16'h0001);
    // Reset values and reserved bits
    for (n = 0; n < 8; n++) begin
      rd_reg(2'h0, n[2:0], rd_val);
      check(rd_val, 16'h0000);
      wr_reg(2'h0, n[2:0], 16'hFFFE);
      rd_reg(2'h0, n[2:0], rd_val);
      check(rd_val, 16'h0000);
    end
    wr_reg(2'h2, 3'h0, 16'hFFFF);
    rd_reg(2'h2, 3'h5, rd_val);
    check(rd_val, 16'h01FF);
    wr_reg(2'h3, 3'h0, 16'hFFFF);
    rd_reg(2'h3, 3'h0, rd_val);
    check(rd_val, 16'h0000);
    // Propagation per channel and pin, responses left at ignore
    for (n = 0; n < 16; n++) begin
      wr_reg(2'h0, n[2:0], {15'h0000, ~n[3]});
      wr_reg(2'h1, n[2:0], {15'h0000, n[3]});
      rd_reg(2'h1, n[2:0], rd_val);
      check(rd_val, {15'h0000, n[3]});
      faulted_off = 8'hFF;
      idle(3);
      check(16'(dev_oe), 16'(4'h1 << (2 * (n[2:0] / 4) + n[3])));
      check(16'(dev_drv & dev_oe), 16'h0000);
      faulted_off = '0;
      wr_reg(2'h0, n[2:0], 16'h0000);
      wr_reg(2'h1, n[2:0], 16'h0000);
      idle(2);
      check(16'(dev_oe), 16'h0000);
    end
    // Zone isolation: upper half drives pin A only, lower half pin B only
    for (n = 0; n < 8; n++) begin
      wr_reg(2'h0, n[2:0], {15'h0000, n[2]});
      wr_reg(2'h1, n[2:0], {15'h0000, ~n[2]});
    end
    faulted_off = 8'hF0;
    idle(3);
    check(16'(dev_oe), 16'h0004);
    faulted_off = 8'h0F;
    idle(3);
    check(16'(dev_oe), 16'h0002);
    faulted_off = '0;
    for (n = 0; n < 8; n++) begin
      wr_reg(2'h0, n[2:0], 16'h0000);
      wr_reg(2'h1, n[2:0], 16'h0000);
    end
    idle(2);
    check(16'(dev_oe), 16'h0000);
    // Long pin pull with responses at zero
    peer_pull = 4'hF;
    idle(420);
    check(16'(shut), 16'h0000);
    peer_pull = '0;
    idle(5);
    // Power-good mask, one source at a time
    for (n = 0; n < 9; n++) begin
      for (h = 0; h < 2; h++) begin
        m = 9'h001 << n;
        hires = h[0] ? 8'hFF : 8'h00;
        pgood = ~(8'h01 << n);
        wdog = (n != 8);
        wr_reg(2'h2, 3'h0, 16'(m));
        idle(3);
        check(16'(pgood_pin), 16'(pg_ref(m, pgood, hires, wdog)));
        wdog = ~wdog;
        pgood = ~pgood;
        idle(3);
        check(16'(pgood_pin), 16'(pg_ref(m, pgood, hires, wdog)));
      end
    end
    wr_reg(2'h2, 3'h0, 16'h0000);
    pgood = '0;
    wdog = 1'b0;
    idle(3);
    check(16'(pgood_pin), 16'h0001);
    // Shared pin qualification, short and long pulls
    resp_a = 8'h0F;
    resp_b = 8'hF0;
    peer_pull = 4'h9;
    idle(200);
    peer_pull = '0;
    idle(300);
    check(16'(shut), 16'h0000);
    peer_pull = 4'h9;
    idle(395);
    check(16'(shut), 16'h0000);
    idle(20);
    check(16'(shut), 16'h00FF);
    check(16'(status), 16'h00FF);
    check(16'({alert_oe, alert_n}), 16'h0002);
    peer_pull = '0;
    idle(10);
    check(16'(shut), 16'h0000);
    check(16'(status), 16'h00FF);
    clr = 8'hFF;
    idle(1);
    clr = '0;
    idle(2);
    check(16'({status, 7'h00, alert_oe}), 16'h0000);
    give_verdict();
  end

  // Hang guard
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end
endmodule

`default_nettype wire
